/* File: adc_seq_pkg.sv */
// Package for the four-channel converter control block: control word layout,
// power modes, result word layout and frame timing.
// Assumes a host that clocks 16-bit frames MSB first over a sampled serial link.
package adc_seq_pkg;

	localparam int FRAME_BITS    = 16;
	localparam int CTRL_BITS     = 12;
	localparam int DATA_BITS     = 12;
	localparam int TRACK_EDGE    = 14;
	localparam int CNT_W         = 5;

	// Control word positions, first received bit is bit 11
	localparam int CB_WRITE      = 11;
	localparam int CB_SEQ_HI     = 10;
	localparam int CB_CHAN_HI    = 7;
	localparam int CB_CHAN_LO    = 6;
	localparam int CB_PWR_HI     = 5;
	localparam int CB_PWR_LO     = 4;
	localparam int CB_SEQ_LO     = 3;
	localparam int CB_RANGE      = 1;
	localparam int CB_CODING     = 0;

	localparam logic [11:0] CTRL_RESET = 12'h000;

	typedef enum logic [1:0] {
		PWR_NONE  = 2'b00,
		PWR_AUTO  = 2'b01,
		PWR_FULL  = 2'b10,
		PWR_NORM  = 2'b11
	} pwr_mode_e;

	typedef struct packed {
		logic [1:0]  chan;
		logic        seq_mode_hi;
		logic        seq_mode_lo;
		pwr_mode_e   pwr;
		logic        range;
		logic        coding;
	} ctrl_s;

	typedef struct packed {
		logic [1:0]           zeros;
		logic [1:0]           chan;
		logic [DATA_BITS-1:0] data;
	} result_s;

endpackage : adc_seq_pkg

/* File: word_buf2.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; a stalled drain side lets it fill and drops in_ready.
`timescale 1ns/1ps
module word_buf2 #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem [2];
	logic             wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [1:0]       count, next_count;
	logic             push, pop;

	always_comb begin
		push        = in_valid && (count != 2'h2);
		pop         = out_ready && (count != 2'h0);
		next_wr_ptr = wr_ptr ^ push;
		next_rd_ptr = rd_ptr ^ pop;
		next_count  = count + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	// Storage has no reset; contents only matter while count says valid
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	assign in_ready  = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_data  = mem[rd_ptr];

endmodule : word_buf2

/* File: adc_seq_ctrl.sv */
// Digital control of a four-channel converter behind a serial slave link.
// Assumes host-driven SCLK, CS_N and DIN pins sampled on CLK, and an analog
// core that returns a 12-bit code per sample through a two-entry buffer.
//
// Overview of operation
// [R1] - Result: two zeros, channel, twelve data bits
// [R2] - Channel select bits route input to converter
// [R3] - Sequence bits 1,1 scan channels upward
// [R4] - First sequenced transfer converts channel zero
// [R5] - Host avoids writes while sequence runs
// [R6] - Host writes sequence bits 1,0 mid-sequence
// [R7] - Other sequence bits on write stop sequence
// [R8] - Sequence wraps to channel zero, repeats
// [R9] - Range bit selects one or two reference spans
// [R10] - Double span twos complement centres on reference
// [R11] - Power bits 1,1 keep normal mode
// [R12] - Chip select fall starts conversion, holds
// [R13] - First twelve bits load when write set
// [R14] - Write bit zero leaves control unchanged
// [R15] - Sixteen clocks; track on fourteenth fall
// [R16] - Host may idle chip select high or low; frames start only on a select fall
// [R17] - Host spaces frames five microseconds apart
// [R18] - Power bits 1,0 give full shutdown
// [R19] - Wake from full shutdown at select rise
// [R20] - Wake frame leaves serial output undriven
// [R21] - Host waits power-up time after wake
// [R22] - Non-sequence mode uses last written channel
// [R23] - Control LSB selects output coding
// [R24] - Power bits 0,1 give auto shutdown
// [R25] - Result shifts out MSB first
`timescale 1ns/1ps
module adc_seq_ctrl
	import adc_seq_pkg::*;
(
	// Clock and reset
	input  wire logic                       CLK,
	input  wire logic                       RST,
	// Serial link pins
	input  wire logic                       SCLK,
	input  wire logic                       CS_N,
	input  wire logic                       DIN,
	output logic                            DOUT,
	output logic                            DOUT_OE,
	// Analog core
	output logic [1:0]                      MUX_SEL,
	output logic                            SAMPLE_HOLD,
	output logic                            RANGE_SEL,
	output logic                            CORE_POWERED,
	input  wire logic                       CODE_VALID,
	output logic                            CODE_READY,
	input  wire logic [adc_seq_pkg::DATA_BITS-1:0] CODE,
	// Status
	output logic                            SEQ_ACTIVE,
	output logic [1:0]                      PWR_MODE
);
	import adc_seq_pkg::*;

	// Pin synchronisers
	logic [1:0] sclk_s, cs_s, din_s;
	logic       sclk_d, cs_d;
	// CS_N resets high so that the release of reset is not taken as a frame start
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sclk_s <= 2'h0;
			cs_s   <= 2'h3;
			din_s  <= 2'h0;
			sclk_d <= 1'b0;
			cs_d   <= 1'b1;
		end else begin
			sclk_s <= {sclk_s[0], SCLK};
			cs_s   <= {cs_s[0], CS_N};
			din_s  <= {din_s[0], DIN};
			sclk_d <= sclk_s[1];
			cs_d   <= cs_s[1];
		end
	end

	// SCLK may idle at either level; its edges only count inside a frame
	logic cs_fall, cs_rise, sclk_rise, sclk_fall, in_frame;
	assign cs_fall   = cs_d && !cs_s[1];
	assign cs_rise   = !cs_d && cs_s[1];
	assign in_frame  = !cs_s[1];
	assign sclk_rise = in_frame && !sclk_d && sclk_s[1];
	assign sclk_fall = in_frame && sclk_d && !sclk_s[1];

	// Result word formatting, used for the buffered code
	function automatic logic [DATA_BITS-1:0] apply_coding(input logic [DATA_BITS-1:0] c,
		input logic twos);
		// Flipping the MSB puts mid-scale (the reference in double span) at zero
		apply_coding = twos ? {~c[DATA_BITS-1], c[DATA_BITS-2:0]} : c; // [R10] [R23]
	endfunction : apply_coding

	// Frame state
	ctrl_s                  ctrl, next_ctrl;
	logic [CTRL_BITS-1:0]   rx, next_rx;
	logic [CNT_W-1:0]       fall_cnt, next_fall_cnt;
	logic [FRAME_BITS-1:0]  tx, next_tx;
	logic [1:0]             seq_chan, next_seq_chan;
	logic                   seq_run, next_seq_run;
	logic                   seq_armed, next_seq_armed;
	logic                   hold, next_hold;
	logic                   powered, next_powered;
	logic                   wake, next_wake;
	logic                   dout, next_dout;
	logic                   dout_oe, next_dout_oe;
	logic [1:0]             conv_chan, next_conv_chan;
	logic                   want_code, next_want_code;
	logic                   buf_valid;
	logic [FRAME_BITS-1:0]  buf_data;
	logic                   buf_in_ready;
	logic                   code_take;
	logic                   code_load;
	logic                   rx_take;
	result_s                res;

	// The core result is paired with the channel sampled for this frame
	always_comb begin
		res.zeros = 2'b00; // [R1]
		res.chan  = conv_chan; // [R1]
		res.data  = apply_coding(CODE, ctrl.coding);
	end

	// Core handshake only while a conversion is wanted
	assign code_take  = want_code && buf_in_ready;
	// One word per frame, moved to the shifter at the first clock fall
	assign code_load  = sclk_fall && fall_cnt == 5'h00 && buf_valid;
	// Twelve control bits: the rises after the first through the twelfth fall
	assign rx_take    = sclk_rise && fall_cnt != 5'h00 && fall_cnt <= 5'(CTRL_BITS);

	// A word left behind by a cut frame is dropped at the next select fall
	word_buf2 #(
		.WIDTH(FRAME_BITS)
	) i_word_buf2 (
		.clk       (CLK),
		.rst       (RST),
		.in_valid  (CODE_VALID && code_take),
		.in_ready  (buf_in_ready),
		.in_data   (res),
		.out_valid (buf_valid),
		.out_ready (cs_fall || code_load),
		.out_data  (buf_data)
	);

	always_comb begin
		logic [1:0] pick;
		logic [1:0] seq_bits;
		logic       wr;
		pick           = 2'h0;
		seq_bits       = 2'h0;
		wr             = 1'b0;
		next_ctrl      = ctrl;
		next_rx        = rx;
		next_fall_cnt  = fall_cnt;
		next_tx        = tx;
		next_seq_chan  = seq_chan;
		next_seq_run   = seq_run;
		next_seq_armed = seq_armed;
		next_hold      = hold;
		next_powered   = powered;
		next_wake      = wake;
		next_dout      = dout;
		next_dout_oe   = dout_oe;
		next_conv_chan = conv_chan;
		next_want_code = want_code;

		// Drop the request once the code is taken, so the buffer holds this frame only
		if (CODE_VALID && code_take) begin
			next_want_code = 1'b0;
		end

		if (cs_fall) begin
			// Channel for this frame: sequencer or last written address
			if (seq_run) begin
				pick = seq_armed ? 2'h0 : seq_chan; // [R3] [R4]
			end else begin
				pick = ctrl.chan; // [R2] [R22]
			end
			next_seq_chan  = pick;
			next_seq_armed = 1'b0;
			next_conv_chan = pick;
			next_hold      = 1'b1; // [R12]
			next_fall_cnt  = 5'h00;
			next_rx        = '0;
			// Auto shutdown wakes here; full shutdown stays down
			if (ctrl.pwr == PWR_AUTO) begin
				next_powered = 1'b1; // [R24]
			end
			next_wake      = !powered && ctrl.pwr == PWR_FULL;
			next_want_code = powered || ctrl.pwr == PWR_AUTO;
			next_dout_oe   = !(ctrl.pwr == PWR_FULL); // [R20]
			next_tx        = '0;
			next_dout      = 1'b0;
		end else if (sclk_fall) begin
			if (fall_cnt < 5'(FRAME_BITS)) begin
				next_fall_cnt = fall_cnt + 5'h01;
			end
			if (fall_cnt + 5'h01 == 5'(TRACK_EDGE)) begin
				next_hold = 1'b0; // [R15] [R19]
			end
			// MSB first, one bit per serial clock
			if (code_load) begin
				next_tx   = {buf_data[FRAME_BITS-2:0], 1'b0}; // [R25]
				next_dout = buf_data[FRAME_BITS-1];
			end else begin
				next_tx   = {tx[FRAME_BITS-2:0], 1'b0};
				next_dout = tx[FRAME_BITS-1]; // [R25]
			end
		end else if (rx_take) begin
			next_rx = {rx[CTRL_BITS-2:0], din_s[1]}; // [R13]
		end else if (cs_rise) begin
			next_dout_oe   = 1'b0;
			next_want_code = 1'b0;
			next_hold      = 1'b0;
			// A frame cut before twelve clock falls cannot write
			wr = rx[CB_WRITE] && fall_cnt >= 5'(CTRL_BITS); // [R13] [R14]
			if (wr) begin
				next_ctrl.chan        = {rx[CB_CHAN_HI], rx[CB_CHAN_LO]};
				next_ctrl.seq_mode_hi = rx[CB_SEQ_HI];
				next_ctrl.seq_mode_lo = rx[CB_SEQ_LO];
				next_ctrl.pwr         = pwr_mode_e'({rx[CB_PWR_HI], rx[CB_PWR_LO]});
				next_ctrl.range       = rx[CB_RANGE]; // [R9]
				next_ctrl.coding      = rx[CB_CODING]; // [R23]
				seq_bits = {rx[CB_SEQ_HI], rx[CB_SEQ_LO]};
				if (seq_bits == 2'b11) begin
					next_seq_run   = 1'b1; // [R3]
					next_seq_armed = 1'b1; // [R4]
				end else if (seq_bits != 2'b10) begin
					next_seq_run   = 1'b0; // [R7]
				end
			end
			// Advance or wrap after each sequenced frame
			if (seq_run && !(wr && seq_bits == 2'b11)) begin
				next_seq_chan = (seq_chan == next_ctrl.chan) ? 2'h0 : seq_chan + 2'h1; // [R8]
			end
			// Power state follows the mode now in force
			case (next_ctrl.pwr)
				PWR_NORM: next_powered = 1'b1; // [R11] [R19]
				PWR_FULL: next_powered = 1'b0; // [R18]
				PWR_AUTO: next_powered = 1'b0; // [R24]
				default:  next_powered = powered;
			endcase
			next_wake = 1'b0;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ctrl      <= ctrl_s'(CTRL_RESET[$bits(ctrl_s)-1:0]);
			rx        <= '0;
			fall_cnt  <= '0;
			tx        <= '0;
			seq_chan  <= 2'h0;
			seq_run   <= 1'b0;
			seq_armed <= 1'b0;
			hold      <= 1'b0;
			powered   <= 1'b0;
			wake      <= 1'b0;
			dout      <= 1'b0;
			dout_oe   <= 1'b0;
			conv_chan <= 2'h0;
			want_code <= 1'b0;
		end else begin
			ctrl      <= next_ctrl;
			rx        <= next_rx;
			fall_cnt  <= next_fall_cnt;
			tx        <= next_tx;
			seq_chan  <= next_seq_chan;
			seq_run   <= next_seq_run;
			seq_armed <= next_seq_armed;
			hold      <= next_hold;
			powered   <= next_powered;
			wake      <= next_wake;
			dout      <= next_dout;
			dout_oe   <= next_dout_oe;
			conv_chan <= next_conv_chan;
			want_code <= next_want_code;
		end
	end

	// Registered outputs
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			DOUT         <= 1'b0;
			DOUT_OE      <= 1'b0;
			MUX_SEL      <= 2'h0;
			SAMPLE_HOLD  <= 1'b0;
			RANGE_SEL    <= 1'b0;
			CORE_POWERED <= 1'b0;
			CODE_READY   <= 1'b0;
			SEQ_ACTIVE   <= 1'b0;
			PWR_MODE     <= 2'h0;
		end else begin
			DOUT         <= next_dout;
			DOUT_OE      <= next_dout_oe && !next_wake; // [R20]
			MUX_SEL      <= next_conv_chan; // [R2]
			SAMPLE_HOLD  <= next_hold;
			RANGE_SEL    <= next_ctrl.range; // [R9]
			CORE_POWERED <= next_powered;
			CODE_READY   <= next_want_code && buf_in_ready;
			SEQ_ACTIVE   <= next_seq_run;
			PWR_MODE     <= next_ctrl.pwr;
		end
	end

endmodule : adc_seq_ctrl

/* File: adc_seq_ctrl_properties.sv */
// Checker for the converter control block, bound to its top ports.
// Assumes slow host framing: chip select idles high between frames.
`timescale 1ns/1ps
module adc_seq_ctrl_checker
	import adc_seq_pkg::*;
(
	// Clock and reset
	input wire logic       CLK,
	input wire logic       RST,
	// Observed ports
	input wire logic       CS_N,
	input wire logic       DOUT_OE,
	input wire logic [1:0] MUX_SEL,
	input wire logic       SAMPLE_HOLD,
	input wire logic       RANGE_SEL,
	input wire logic       CORE_POWERED,
	input wire logic       CODE_READY,
	input wire logic       SEQ_ACTIVE,
	input wire logic [1:0] PWR_MODE
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	property p_hold; $fell(CS_N) |-> ##[1:8] SAMPLE_HOLD; endproperty
	a_hold: assert property (p_hold) else $error("no hold after select");
	property p_oe_idle; CS_N [*8] |-> !DOUT_OE; endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("output driven idle");
	property p_track; (CS_N && PWR_MODE == PWR_NORM) [*8] |-> !SAMPLE_HOLD; endproperty
	a_track: assert property (p_track) else $error("no tracking idle");
	property p_rdy_idle; CS_N [*8] |-> !CODE_READY; endproperty
	a_rdy_idle: assert property (p_rdy_idle) else $error("code wanted idle");
	property p_full_off; (PWR_MODE == PWR_FULL) [*3] |-> !CORE_POWERED; endproperty
	a_full_off: assert property (p_full_off) else $error("core on in shutdown");
	property p_full_oe; (PWR_MODE == PWR_FULL) [*3] |-> !DOUT_OE; endproperty
	a_full_oe: assert property (p_full_oe) else $error("driven in shutdown");
	property p_norm_on; (PWR_MODE == PWR_NORM) [*8] |-> CORE_POWERED; endproperty
	a_norm_on: assert property (p_norm_on) else $error("core off in normal");
	property p_frozen; (!CS_N) [*8] |=> $stable({PWR_MODE, RANGE_SEL, SEQ_ACTIVE}); endproperty
	a_frozen: assert property (p_frozen) else $error("control moved in frame");
	property p_mux; (!CS_N) [*8] |=> $stable(MUX_SEL); endproperty
	a_mux: assert property (p_mux) else $error("channel moved in frame");
	c_seq: cover property ($rose(SEQ_ACTIVE));
	c_off: cover property ($fell(CORE_POWERED));
	c_auto: cover property (PWR_MODE == PWR_AUTO);
endmodule : adc_seq_ctrl_checker

bind adc_seq_ctrl adc_seq_ctrl_checker i_adc_seq_ctrl_checker (
	.CLK(CLK), .RST(RST), .CS_N(CS_N), .DOUT_OE(DOUT_OE), .MUX_SEL(MUX_SEL),
	.SAMPLE_HOLD(SAMPLE_HOLD), .RANGE_SEL(RANGE_SEL), .CORE_POWERED(CORE_POWERED),
	.CODE_READY(CODE_READY), .SEQ_ACTIVE(SEQ_ACTIVE), .PWR_MODE(PWR_MODE));

/* File: adc_host_model.sv */
// Host serial master: 16-clock frames, control word first, result sampled.
// Assumes CLK is the system clock; each serial level lasts six CLK cycles.
`timescale 1ns/1ps
module adc_host_model (
	// Clock
	input wire logic CLK,
	// Serial link
	output logic     SCLK,
	output logic     CS_N,
	output logic     DIN,
	input wire logic DOUT,
	input wire logic DOUT_OE
);
	initial begin
		SCLK = 1'b1;
		CS_N = 1'b1;
		DIN  = 1'b0;
	end
	task automatic xfer(input logic [11:0] c, output logic [15:0] w, output logic oe);
		oe = 1'b0;
		@(negedge CLK) CS_N = 1'b0;
		repeat (6) @(negedge CLK);
		for (int i = 0; i < 16; i++) begin
			SCLK = 1'b0;
			DIN  = (i < 12) ? c[11-i] : ~DIN;
			repeat (6) @(negedge CLK);
			SCLK  = 1'b1;
			// An undriven line reads as the inverse of the current DOUT level
			w[15-i] = DOUT_OE ? DOUT : ~DOUT;
			oe    = oe | DOUT_OE;
			repeat (6) @(negedge CLK);
		end
		CS_N = 1'b1;
		DIN  = ~DIN;
		// Keeps falls over five microseconds apart and covers power-up
		repeat (60) @(negedge CLK);
	endtask : xfer
endmodule : adc_host_model

/* File: adc_seq_ctrl_tb.sv */
// Self-checking bench for the converter control block.
// Assumes the host model above and a core that echoes the routed channel.
`timescale 1ns/1ps
module adc_seq_ctrl_tb;
	import adc_seq_pkg::*;
	logic        CLK, RST, SCLK, CS_N, DIN, DOUT, DOUT_OE, SAMPLE_HOLD, RANGE_SEL;
	logic        CORE_POWERED, CODE_VALID, CODE_READY, SEQ_ACTIVE;
	logic [1:0]  MUX_SEL, PWR_MODE;
	logic [11:0] CODE;
	logic [15:0] w;
	logic        oe;
	int          errors, tests_run;
	adc_seq_ctrl i_adc_seq_ctrl (.CLK(CLK), .RST(RST), .SCLK(SCLK), .CS_N(CS_N),
		.DIN(DIN), .DOUT(DOUT), .DOUT_OE(DOUT_OE), .MUX_SEL(MUX_SEL),
		.SAMPLE_HOLD(SAMPLE_HOLD), .RANGE_SEL(RANGE_SEL), .CORE_POWERED(CORE_POWERED),
		.CODE_VALID(CODE_VALID), .CODE_READY(CODE_READY), .CODE(CODE),
		.SEQ_ACTIVE(SEQ_ACTIVE), .PWR_MODE(PWR_MODE));
	adc_host_model i_adc_host_model (.CLK(CLK), .SCLK(SCLK), .CS_N(CS_N), .DIN(DIN),
		.DOUT(DOUT), .DOUT_OE(DOUT_OE));
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end
	// Core answers one cycle late; code carries the routed channel
	always @(negedge CLK) begin
		CODE_VALID <= CODE_READY;
		CODE       <= {MUX_SEL, 10'h1a5};
	end
	function automatic logic [11:0] ctl(logic wr, logic sh, logic sl, logic [1:0] ch,
		logic [1:0] pm, logic r, logic cd);
		return {wr, sh, 2'b00, ch, pm, sl, 1'b0, r, cd};
	endfunction : ctl
	function automatic logic [15:0] res(logic [1:0] ch, logic t);
		return {2'b00, ch, ch[1] ^ t, ch[0], 10'h1a5};
	endfunction : res
	task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : cmp16
	task automatic cmp2(input logic [1:0] g, input logic [1:0] e);
		cmp16({14'h0, g}, {14'h0, e});
	endtask : cmp2
	task automatic xf(input logic [11:0] c);
		i_adc_host_model.xfer(c, w, oe);
	endtask : xf
	task automatic t_select;
		xf(ctl(1, 0, 0, 2'd0, PWR_NORM, 1, 0));
		for (int c = 1; c < 5; c++) begin
			xf(ctl(1, 0, 0, c[1:0], PWR_NORM, 1, 0));
			cmp16(w, res(c[1:0] - 2'd1, 0));
		end
		cmp2(PWR_MODE, PWR_NORM);
		cmp2({1'b0, RANGE_SEL}, 2'h1);
	endtask : t_select
	task automatic t_nowrite;
		xf(ctl(0, 1, 1, 2'd3, PWR_FULL, 0, 1));
		cmp16(w, res(2'd0, 0));
		cmp2(PWR_MODE, PWR_NORM);
		xf(ctl(0, 0, 0, 2'd3, PWR_AUTO, 0, 1));
		cmp16(w, res(2'd0, 0));
		cmp2({SEQ_ACTIVE, RANGE_SEL}, 2'h1);
	endtask : t_nowrite
	task automatic t_coding;
		xf(ctl(1, 0, 0, 2'd1, PWR_NORM, 0, 1));
		cmp2({1'b0, RANGE_SEL}, 2'h0);
		xf(ctl(1, 0, 0, 2'd1, PWR_NORM, 0, 0));
		cmp16(w, res(2'd1, 1));
	endtask : t_coding
	task automatic t_seq;
		xf(ctl(1, 1, 1, 2'd2, PWR_NORM, 1, 0));
		cmp2({1'b0, SEQ_ACTIVE}, 2'h1);
		for (int i = 0; i < 4; i++) begin
			xf(ctl(0, 0, 0, 2'd0, PWR_NORM, 1, 0));
			cmp16(w, res(2'(i % 3), 0));
		end
		xf(ctl(1, 1, 0, 2'd2, PWR_NORM, 1, 0));
		cmp16(w, res(2'd1, 0));
		xf(ctl(0, 0, 0, 2'd0, PWR_NORM, 1, 0));
		cmp16(w, res(2'd2, 0));
		xf(ctl(1, 0, 0, 2'd3, PWR_NORM, 1, 0));
		cmp16(w, res(2'd0, 0));
		cmp2({1'b0, SEQ_ACTIVE}, 2'h0);
		xf(ctl(0, 0, 0, 2'd0, PWR_NORM, 1, 0));
		cmp16(w, res(2'd3, 0));
	endtask : t_seq
	task automatic t_power;
		xf(ctl(1, 0, 0, 2'd0, PWR_FULL, 1, 0));
		cmp2(PWR_MODE, PWR_FULL);
		cmp2({1'b0, CORE_POWERED}, 2'h0);
		xf(ctl(0, 0, 0, 2'd0, PWR_NORM, 1, 0));
		cmp2(PWR_MODE, PWR_FULL);
		xf(ctl(1, 0, 0, 2'd0, PWR_NORM, 1, 0));
		cmp2({1'b0, oe}, 2'h0);
		cmp2(PWR_MODE, PWR_NORM);
		cmp2({1'b0, CORE_POWERED}, 2'h1);
		xf(ctl(1, 0, 0, 2'd0, PWR_AUTO, 1, 0));
		cmp16(w, res(2'd0, 0));
		cmp2(PWR_MODE, PWR_AUTO);
		xf(ctl(0, 0, 0, 2'd0, PWR_NORM, 1, 0));
		cmp16(w, res(2'd0, 0));
	endtask : t_power
	task automatic print_verdict;
		if (errors == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict
	initial begin
		repeat (40000) @(posedge CLK);
		errors++;
		print_verdict();
	end
	initial begin
		errors     = 0;
		tests_run  = 0;
		RST        = 1'b1;
		repeat (20) @(posedge CLK);
		@(negedge CLK) RST = 1'b0;
		repeat (4) @(negedge CLK);
		t_select();
		t_nowrite();
		t_coding();
		t_seq();
		t_power();
		print_verdict();
	end
endmodule : adc_seq_ctrl_tb
